// ===== t8h_pkg.sv
/*
 * Constants for the 8-bit interval / PWM timer: register addresses, mode register fields,
 * reset values and timing figures.
 * Assumes a byte-wide register port with a 16-bit address, driven on core_clk.
 */
package t8h_pkg;

	// ----------------------------------------------------------------
	// register addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] T8H_ADDR_PORT1_DIR = 16'hff21;
	localparam logic [15:0] T8H_ADDR_PORT1_LATCH = 16'hff01;
	localparam logic [15:0] T8H_ADDR_PERIOD = 16'hff0e;
	localparam logic [15:0] T8H_ADDR_DUTY = 16'hff0f;
	localparam logic [15:0] T8H_ADDR_MODE = 16'hff69;
	localparam logic [15:0] T8H_ADDR_COUNT = 16'hff6a;

	// ----------------------------------------------------------------
	// mode register fields
	// ----------------------------------------------------------------
	localparam int T8H_MODE_EN_BIT = 7;
	localparam int T8H_MODE_CKS_LSB = 4;
	localparam int T8H_MODE_MD_LSB = 2;
	localparam int T8H_MODE_LEV_BIT = 1;
	localparam int T8H_MODE_OE_BIT = 0;
	localparam logic [1:0] T8H_MD_INTERVAL = 2'h0;
	localparam logic [1:0] T8H_MD_PWM = 2'h2;

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] T8H_RST_PORT1_DIR = 8'hff;
	localparam logic [7:0] T8H_RST_ZERO = 8'h00;
	localparam logic [1:0] T8H_DUTY_SETTLE = 2'h3;
	localparam int T8H_TIMER_PIN = 5;

endpackage

// ===== t8h_timer.sv
/*
 * 8-bit up-counting timer with period and duty compare, interval and PWM modes,
 * plus the port 1 direction and output latch registers that route its output to a pin.
 * Assumes the register port is synchronous to core_clk; no assertions live here.
 */
`timescale 1ns/10ps
module t8h_timer #(
	parameter int CNT_W = 8
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic match_irq,
	output logic timer_out_pin,
	output logic [7:0] port1_out,
	output logic [7:0] port1_oe
);
	import t8h_pkg::*;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] port1_direction;
	logic [7:0] port1_latch;
	logic [7:0] timer_mode_reg;
	logic [CNT_W-1:0] period_compare;
	logic [CNT_W-1:0] duty_compare;
	logic [CNT_W-1:0] duty_active;
	logic [CNT_W-1:0] count;
	logic [7:0] prescale;
	logic duty_pending;
	logic [1:0] duty_age;
	logic cmp_duty;
	logic first_mask;
	logic out_act;
	logic tick;

	logic count_enable_bit;
	logic [2:0] clock_select_field;
	logic [1:0] mode;
	logic out_level_bit;
	logic out_enable_bit;
	logic wr_mode;
	logic wr_duty;
	logic start;
	logic period_hit;
	logic duty_hit;

	function automatic logic addr_is(input logic [15:0] a, input logic [15:0] b);
		addr_is = (a == b);
	endfunction

	assign count_enable_bit = timer_mode_reg[T8H_MODE_EN_BIT];
	assign clock_select_field = timer_mode_reg[T8H_MODE_CKS_LSB +: 3];
	assign mode = timer_mode_reg[T8H_MODE_MD_LSB +: 2];
	assign out_level_bit = timer_mode_reg[T8H_MODE_LEV_BIT];
	assign out_enable_bit = timer_mode_reg[T8H_MODE_OE_BIT];
	assign wr_mode = reg_wr && addr_is(reg_addr, T8H_ADDR_MODE);
	assign wr_duty = reg_wr && addr_is(reg_addr, T8H_ADDR_DUTY);
	assign start = wr_mode && reg_wdata[T8H_MODE_EN_BIT] && !count_enable_bit;
	assign period_hit = (count == period_compare) && !(mode == T8H_MD_PWM && cmp_duty);
	// duty compare only exists in pwm mode
	assign duty_hit = (mode == T8H_MD_PWM) && cmp_duty && (count == duty_active);

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			port1_direction <= T8H_RST_PORT1_DIR;
			port1_latch <= T8H_RST_ZERO;
			period_compare <= '0;
			duty_compare <= '0;
		end else if (reg_wr) begin
			if (addr_is(reg_addr, T8H_ADDR_PORT1_DIR))
				port1_direction <= reg_wdata;
			if (addr_is(reg_addr, T8H_ADDR_PORT1_LATCH))
				port1_latch <= reg_wdata;
			// period is trusted not to change while running
			if (addr_is(reg_addr, T8H_ADDR_PERIOD))
				period_compare <= reg_wdata[CNT_W-1:0];
			if (wr_duty)
				duty_compare <= reg_wdata[CNT_W-1:0];
		end
	end

	// other mode bits are frozen while counting
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_mode_reg <= T8H_RST_ZERO;
		end else if (wr_mode) begin
			if (count_enable_bit)
				timer_mode_reg[T8H_MODE_EN_BIT] <= reg_wdata[T8H_MODE_EN_BIT];
			else
				timer_mode_reg <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= T8H_RST_ZERO;
		end else if (reg_rd) begin
			case (reg_addr)
				T8H_ADDR_PORT1_DIR: reg_rdata <= port1_direction;
				T8H_ADDR_PORT1_LATCH: reg_rdata <= port1_latch;
				T8H_ADDR_PERIOD: reg_rdata <= 8'(period_compare);
				T8H_ADDR_DUTY: reg_rdata <= 8'(duty_compare);
				T8H_ADDR_MODE: reg_rdata <= timer_mode_reg;
				T8H_ADDR_COUNT: reg_rdata <= 8'(count);
				default: reg_rdata <= T8H_RST_ZERO;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// count clock: core_clk divided by 2^clock_select_field
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prescale <= T8H_RST_ZERO;
			tick <= 1'b0;
		end else if (!count_enable_bit) begin
			prescale <= T8H_RST_ZERO;
			tick <= 1'b0;
		end else begin
			prescale <= prescale + 8'h01;
			tick <= ((prescale & ((8'h01 << clock_select_field) - 8'h01)) == 8'h00);
		end
	end

	// ----------------------------------------------------------------
	// duty double buffer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			duty_active <= '0;
			duty_pending <= 1'b0;
			duty_age <= 2'h0;
		end else if (!count_enable_bit) begin
			duty_active <= duty_compare;
			duty_pending <= 1'b0;
			duty_age <= 2'h0;
		end else if (wr_duty) begin
			duty_pending <= 1'b1;
			duty_age <= 2'h0;
		end else if (tick) begin
			// new value moves over on a duty match, only once it has aged three count clocks
			if (duty_hit && !first_mask && duty_pending && duty_age == T8H_DUTY_SETTLE) begin
				duty_active <= duty_compare;
				duty_pending <= 1'b0;
			end else if (duty_age != T8H_DUTY_SETTLE) begin
				duty_age <= duty_age + 2'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// counter, compare select and output state
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
			cmp_duty <= 1'b0;
			first_mask <= 1'b0;
			out_act <= 1'b0;
			match_irq <= 1'b0;
		end else if (!count_enable_bit) begin
			count <= '0;
			cmp_duty <= 1'b0;
			first_mask <= start && reg_wdata[T8H_MODE_MD_LSB +: 2] == T8H_MD_PWM;
			out_act <= 1'b0;
			match_irq <= 1'b0;
		end else begin
			match_irq <= 1'b0;
			if (tick) begin
				if (first_mask) begin
					first_mask <= 1'b0;
				end else if (period_hit) begin
					count <= '0;
					match_irq <= 1'b1;
					if (mode == T8H_MD_PWM) begin
						out_act <= 1'b1;
						cmp_duty <= 1'b1;
					end else begin
						out_act <= !out_act;
					end
				end else begin
					count <= count + 1'b1;
					if (duty_hit) begin
						out_act <= 1'b0;
						cmp_duty <= 1'b0;
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_out_pin <= 1'b0;
			port1_out <= T8H_RST_ZERO;
			port1_oe <= T8H_RST_ZERO;
		end else begin
			// active level is the inverse of the default level
			timer_out_pin <= out_enable_bit ? (out_act ^ out_level_bit) : out_level_bit;
			port1_oe <= ~port1_direction;
			port1_out <= port1_latch;
			// timer output ORs onto the latch, so a zero latch passes it through
			port1_out[T8H_TIMER_PIN] <= port1_latch[T8H_TIMER_PIN]
				| (out_enable_bit ? (out_act ^ out_level_bit) : out_level_bit);
		end
	end

endmodule

// ===== t8h_timer_assertions.sv
/* port checker for t8h_timer: shadows mode, period and direction writes
   assumes it is bound to the timer top by the bench */
`timescale 1ns/10ps
module t8h_timer_chk (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic match_irq,
	input wire logic timer_out_pin,
	input wire logic [7:0] port1_out,
	input wire logic [7:0] port1_oe
);
	import t8h_pkg::*;
	logic [7:0] mode, per, dir, gap;
	logic [1:0] dage;
	logic seen;
	// only the enable bit is writable while running
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode <= 8'h00;
			per <= 8'h00;
			dir <= 8'hff;
			dage <= 2'h3;
		end else begin
			if (reg_wr && reg_addr == T8H_ADDR_MODE)
				mode <= mode[7] ? {reg_wdata[7], mode[6:0]} : reg_wdata;
			if (reg_wr && reg_addr == T8H_ADDR_PERIOD)
				per <= reg_wdata;
			if (reg_wr && reg_addr == T8H_ADDR_PORT1_DIR)
				dir <= reg_wdata;
			dage <= (reg_wr && reg_addr == T8H_ADDR_PORT1_DIR) ? 2'h0 : dage + {1'b0, dage != 2'h3};
		end
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			gap <= 8'h00;
			seen <= 1'b0;
		end else begin
			gap <= match_irq ? 8'h01 : gap + 8'h01;
			seen <= mode[7] && (seen || match_irq);
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	sequence stopped;
		(!mode[7] && $stable(mode))[*3];
	endsequence
	sequence out_off;
		(!mode[0] && $stable(mode[1]))[*3];
	endsequence
	chk_irq_one_cycle: assert property (match_irq |=> !match_irq)
		else $error("interrupt longer than one cycle");
	chk_irq_period_gap: assert property (match_irq && seen && mode[6:4] == 3'h0 |-> gap == per + 8'h01)
		else $error("interrupt spacing wrong");
	chk_stop_irq_low: assert property (stopped |-> !match_irq)
		else $error("interrupt while stopped");
	chk_stop_pin_default: assert property (stopped |-> timer_out_pin == mode[1])
		else $error("pin not at default while stopped");
	chk_oe_low_pin: assert property (out_off |-> timer_out_pin == mode[1])
		else $error("pin moved with output disabled");
	chk_dir_drive_oe: assert property (dage == 2'h3 |-> port1_oe == ~dir)
		else $error("output enables differ from direction");
	chk_dir_read_back: assert property (reg_rd && !reg_wr && reg_addr == T8H_ADDR_PORT1_DIR |=> reg_rdata == $past(dir))
		else $error("direction read wrong");
	chk_unmapped_read: assert property (reg_rd && reg_addr == 16'h0000 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule

// ===== t8h_pin_load.sv
/* load on port 1 pin 5: measures high and low run lengths in core_clk cycles
   assumes a pull-up holds the pin high when undriven */
`timescale 1ns/10ps
module t8h_pin_load (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic drive,
	input wire logic drive_en,
	output logic [7:0] hi_w,
	output logic [7:0] lo_w
);
	logic [7:0] run;
	logic prev;
	logic level;
	assign level = drive_en ? drive : 1'b1;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prev <= 1'b1;
			run <= 8'h00;
			hi_w <= 8'h00;
			lo_w <= 8'h00;
		end else begin
			prev <= level;
			run <= (level != prev) ? 8'h01 : run + 8'h01;
			if (level != prev && prev)
				hi_w <= run;
			if (level != prev && !prev)
				lo_w <= run;
		end
	end
endmodule

// ===== t8h_timer_bench.sv
/* bench for t8h_timer: register tasks, interval and PWM scenarios
   assumes the pin load model and the checker module */
`timescale 1ns/10ps
bind t8h_timer t8h_timer_chk u_chk (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.match_irq(match_irq), .timer_out_pin(timer_out_pin), .port1_out(port1_out), .port1_oe(port1_oe));
module timer8_interval_pwm_bench;
	import t8h_pkg::*;
	logic core_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, match_irq, timer_out_pin;
	logic [15:0] reg_addr = '0;
	logic [7:0] reg_wdata = '0, reg_rdata, port1_out, port1_oe, hi_w, lo_w;
	int fail_count = 0, compares = 0, n;
	always #5 core_clk = ~core_clk;
	t8h_timer DUT (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .match_irq(match_irq),
		.timer_out_pin(timer_out_pin), .port1_out(port1_out), .port1_oe(port1_oe));
	t8h_pin_load u_load (.core_clk(core_clk), .rst_b(rst_b), .drive(port1_out[5]),
		.drive_en(port1_oe[5]), .hi_w(hi_w), .lo_w(lo_w));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk) #1;
		{reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(posedge core_clk) #1;
		reg_wr = 0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge core_clk) #1;
		{reg_addr, reg_rd} = {a, 1'b1};
		@(posedge core_clk) #1;
		reg_rd = 0;
		chk(reg_rdata, exp);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic summarize;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		summarize;
	end
	initial begin
		cyc(20);
		rst_b = 1;
		rd(T8H_ADDR_PORT1_DIR, 8'hff);
		chk(port1_oe, 8'h00);
		wr(T8H_ADDR_PORT1_DIR, 8'hdf);
		wr(T8H_ADDR_PORT1_LATCH, 8'h00);
		rd(T8H_ADDR_PORT1_DIR, 8'hdf);
		chk(port1_oe, 8'h20);
		rd(16'h0000, 8'h00);
		// interval: period 4, duty set but unused
		wr(T8H_ADDR_PERIOD, 8'h04);
		wr(T8H_ADDR_DUTY, 8'h01);
		wr(T8H_ADDR_MODE, 8'h81);
		cyc(40);
		chk(hi_w, 8'h05);
		chk(lo_w, 8'h05);
		n = 0;
		repeat (50) begin
			cyc(1);
			n += match_irq;
		end
		chk(n[7:0], 8'h0a);
		// stop just after a rising pin edge, so the pin is active when stopped
		n = 0;
		while (timer_out_pin !== 1'b0 && n < 20) begin
			cyc(1);
			n++;
		end
		while (timer_out_pin !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		chk(timer_out_pin, 1'b1);
		wr(T8H_ADDR_MODE, 8'h00);
		// a square wave still running would be high again here
		cyc(10);
		chk(timer_out_pin, 1'b0);
		rd(T8H_ADDR_COUNT, 8'h00);
		// PWM: period 9, duty 3, then duty 5 while running
		wr(T8H_ADDR_PERIOD, 8'h09);
		wr(T8H_ADDR_MODE, 8'h09);
		wr(T8H_ADDR_DUTY, 8'h03);
		wr(T8H_ADDR_MODE, 8'h89);
		// first count clock is masked, so the counter lags one behind
		rd(T8H_ADDR_COUNT, 8'h00);
		rd(T8H_ADDR_COUNT, 8'h01);
		chk(timer_out_pin, 1'b0);
		cyc(40);
		chk(hi_w, 8'h04);
		chk(lo_w, 8'h06);
		wr(T8H_ADDR_DUTY, 8'h05);
		cyc(40);
		chk(hi_w, 8'h06);
		chk(lo_w, 8'h04);
		// level high: active low pulse
		wr(T8H_ADDR_MODE, 8'h00);
		wr(T8H_ADDR_MODE, 8'h0b);
		cyc(3);
		chk(timer_out_pin, 1'b1);
		wr(T8H_ADDR_DUTY, 8'h05);
		wr(T8H_ADDR_MODE, 8'h8b);
		cyc(40);
		chk(lo_w, 8'h06);
		chk(hi_w, 8'h04);
		// output disabled, then an ignored enable attempt while running
		wr(T8H_ADDR_MODE, 8'h00);
		wr(T8H_ADDR_MODE, 8'h02);
		wr(T8H_ADDR_MODE, 8'h82);
		wr(T8H_ADDR_MODE, 8'h83);
		rd(T8H_ADDR_MODE, 8'h82);
		n = 0;
		repeat (30) begin
			cyc(1);
			n += (timer_out_pin !== 1'b1);
		end
		chk(n[7:0], 8'h00);
		chk(timer_out_pin, 1'b1);
		wr(T8H_ADDR_MODE, 8'h00);
		// count clock divided by two: one count per two core clocks
		wr(T8H_ADDR_PERIOD, 8'hff);
		wr(T8H_ADDR_MODE, 8'h90);
		rd(T8H_ADDR_COUNT, 8'h00);
		rd(T8H_ADDR_COUNT, 8'h01);
		cyc(20);
		rd(T8H_ADDR_COUNT, 8'h0c);
		wr(T8H_ADDR_MODE, 8'h00);
		summarize;
	end
endmodule
